/* File: shared/cdc_ctrl_cfg.svh */
// offsets, field positions, reset values and timing figures of the
// power-control and calibration-enable registers.
// assumes: included by bare name, after nothing else.
`ifndef CDC_CTRL_CFG_SVH
`define CDC_CTRL_CFG_SVH

// register indices, one 16-bit register per address
`define ADDR_W 10
`define ADDR_POWER_CONTROL 10'h000
`define ADDR_STAGE_CAL_EN 10'h001
`define ADDR_MAX 10'h3FF
`define REG_RESET 16'h0000

// power_control fields
`define PC_MODE_LSB 0
`define PC_DELAY_LSB 2
`define PC_STAGES_LSB 4
`define PC_DECIM_LSB 8
`define PC_SOFT_RESET_BIT 10
`define PC_IRQ_POL_BIT 11
`define PC_EXC_DIS_BIT 12
`define PC_RESERVED_BIT 13
`define PC_BIAS_LSB 14

// stage_calibration_enable fields
`define SC_STAGES 12
`define SC_FP_SKIP_LSB 12
`define SC_LP_SKIP_LSB 14
`define STAGE_MAX 4'hB

// timing: clock rate and intervals in their own units
`define CLK_KHZ 250000
`define FP_INTERVAL_MS 36
`define LP_DELAY_UNIT_MS 200

`endif

/* File: shared/cdc_ctrl_pkg.sv */
// types shared by the power and calibration control block.
// assumes: compiled before the design module.
package cdc_ctrl_pkg;

  // two-bit operating mode field
  typedef enum logic [1:0] {
    MODE_FULL = 2'b00,
    MODE_OFF_A = 2'b01,
    MODE_LOW = 2'b10,
    MODE_OFF_B = 2'b11
  } power_mode_e;

  // conversion scheduler state
  typedef enum logic [1:0] {
    SEQ_OFF = 2'b00,
    SEQ_FULL = 2'b01,
    SEQ_LOW = 2'b10
  } seq_state_e;

endpackage : cdc_ctrl_pkg

/* File: design/cdc_power_and_cal_control.sv */
// power-control and calibration-enable registers of a capacitance
// sensing controller, with decoded controls and the wake-up scheduler.
// assumes: the serial front end runs on I_CLOCK and delivers one-cycle
// address, write and read strobes; the converter lives outside.
//
// Notes on behaviour
// - mode 00: convert every 36 ms
// - modes 01 and 11: shutdown, no conversions
// - mode 10: low power, self wake-up
// - wake delay 200/400/600/800 ms by code
// - stages per sequence N+1, at most twelve
// - decimation 256, 128, 64, 64
// - soft reset clears all registers, self-clearing
// - irq polarity: 0 low, 1 high
// - excitation on when bit clear
// - bias plus 0, 20, 35, 50 percent
// - full power skip 3, 7, 15, 31
// - low power skip 0, 1, 2
// - all fields reset zero; addresses 0x000, 0x001
// - pointer advances after each read, except at 0x3FF
`include "cdc_ctrl_cfg.svh"

module cdc_power_and_cal_control #(
  parameter int unsigned FP_INTERVAL_CYC = `FP_INTERVAL_MS * `CLK_KHZ,
  parameter int unsigned LP_UNIT_CYC = `LP_DELAY_UNIT_MS * `CLK_KHZ
) (
  // clock and reset
  input wire logic I_CLOCK,
  input wire logic I_RST_N,
  // register access from the serial front end
  input wire logic i_addr_load,
  input wire logic [`ADDR_W-1:0] i_addr,
  input wire logic i_wr,
  input wire logic [15:0] i_wr_data,
  input wire logic i_rd,
  output logic [15:0] o_rd_data,
  output logic o_rd_valid,
  // decoded controls to the converter
  output cdc_ctrl_pkg::power_mode_e o_mode,
  output logic o_conv_start,
  output logic [3:0] o_stage_count,
  output logic [8:0] o_decim_ratio,
  output logic o_irq_polarity,
  output logic o_excitation_enable,
  output logic [5:0] o_bias_pct,
  output logic [`SC_STAGES-1:0] o_calib_enable,
  output logic [4:0] o_skip_samples
);
  import cdc_ctrl_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // decoders

  // sample skip for the active mode; low-power code 11 is undefined and
  // is taken as two, the most conservative documented figure
  function automatic logic [4:0] skip_of(input power_mode_e m,
                                         input logic [15:0] cal);
    if (m == MODE_LOW)
      skip_of = (cal[`SC_LP_SKIP_LSB +: 2] == 2'h3) ? 5'h02 :
                {3'h0, cal[`SC_LP_SKIP_LSB +: 2]};
    else
      skip_of = (5'h04 << cal[`SC_FP_SKIP_LSB +: 2]) - 5'h01;
  endfunction : skip_of

  function automatic logic [31:0] period_of(input power_mode_e m,
                                            input logic [1:0] dly);
    if (m == MODE_LOW)
      period_of = 32'(LP_UNIT_CYC) * 32'({30'h0, dly} + 32'h1);
    else
      period_of = 32'(FP_INTERVAL_CYC);
  endfunction : period_of

  ////////////////////////////////////////////////////////////////////////
  // registers and address pointer

  logic [15:0] power_control;
  logic [15:0] stage_cal;
  logic [`ADDR_W-1:0] ptr;
  logic [15:0] next_power_control;
  logic [15:0] next_stage_cal;
  logic [`ADDR_W-1:0] next_ptr;
  logic [15:0] next_rd_data;
  logic next_rd_valid;
  logic [15:0] sel_data;

  // access: load beats write beats read; both data strobes advance the
  // pointer, which sticks at the top so reads repeat the last register
  always_comb
  begin
    next_power_control = power_control;
    next_stage_cal = stage_cal;
    next_ptr = ptr;
    next_rd_data = o_rd_data;
    next_rd_valid = 1'b0;
    case (ptr)
      `ADDR_POWER_CONTROL: sel_data = power_control;
      `ADDR_STAGE_CAL_EN: sel_data = stage_cal;
      default: sel_data = 16'h0000;
    endcase
    if (i_addr_load)
    begin
      next_ptr = i_addr;
    end
    else if (i_wr)
    begin
      if (ptr == `ADDR_POWER_CONTROL)
      begin
        next_power_control = i_wr_data;
        next_power_control[`PC_RESERVED_BIT] = 1'b0;
        next_power_control[`PC_SOFT_RESET_BIT] = 1'b0;
      end
      if (ptr == `ADDR_STAGE_CAL_EN)
        next_stage_cal = i_wr_data;
      if (ptr != `ADDR_MAX)
        next_ptr = ptr + `ADDR_W'(1);
      // soft reset wipes both registers, including this write's data
      if (ptr == `ADDR_POWER_CONTROL && i_wr_data[`PC_SOFT_RESET_BIT])
      begin
        next_power_control = `REG_RESET;
        next_stage_cal = `REG_RESET;
      end
    end
    else if (i_rd)
    begin
      next_rd_data = sel_data;
      next_rd_valid = 1'b1;
      if (ptr != `ADDR_MAX)
        next_ptr = ptr + `ADDR_W'(1);
    end
  end

  // register state; everything comes up zero
  always_ff @(posedge I_CLOCK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      power_control <= `REG_RESET;
      stage_cal <= `REG_RESET;
      ptr <= `ADDR_W'(0);
      o_rd_data <= 16'h0000;
      o_rd_valid <= 1'b0;
    end
    else
    begin
      power_control <= next_power_control;
      stage_cal <= next_stage_cal;
      ptr <= next_ptr;
      o_rd_data <= next_rd_data;
      o_rd_valid <= next_rd_valid;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // conversion scheduler

  seq_state_e state;
  seq_state_e next_state;
  logic [31:0] tick;
  logic [31:0] next_tick;
  logic next_conv_start;
  power_mode_e mode_w;

  // a mode or delay change restarts the interval so the first wake-up
  // after a change never comes early
  always_comb
  begin
    mode_w = power_mode_e'(power_control[`PC_MODE_LSB +: 2]);
    next_tick = tick + 32'h1;
    next_conv_start = 1'b0;
    case (mode_w)
      MODE_FULL: next_state = SEQ_FULL;
      MODE_LOW: next_state = SEQ_LOW;
      default: next_state = SEQ_OFF;
    endcase
    case (state)
      SEQ_FULL, SEQ_LOW:
      begin
        if (next_state != state || next_power_control != power_control)
          next_tick = 32'h0;
        else if (tick >= period_of(mode_w,
                 power_control[`PC_DELAY_LSB +: 2]) - 32'h1)
        begin
          next_tick = 32'h0;
          next_conv_start = 1'b1;
        end
      end
      SEQ_OFF: next_tick = 32'h0;
      default: next_tick = 32'h0;
    endcase
  end

  always_ff @(posedge I_CLOCK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      state <= SEQ_OFF;
      tick <= 32'h0;
      o_conv_start <= 1'b0;
    end
    else
    begin
      state <= next_state;
      tick <= next_tick;
      o_conv_start <= next_conv_start;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // decoded controls, registered straight from the next register contents

  logic [3:0] stg;
  logic [1:0] dec;
  logic [1:0] bia;

  // fields of the value about to be stored, so outputs track the register
  assign stg = next_power_control[`PC_STAGES_LSB +: 4];
  assign dec = next_power_control[`PC_DECIM_LSB +: 2];
  assign bia = next_power_control[`PC_BIAS_LSB +: 2];

  always_ff @(posedge I_CLOCK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      o_mode <= MODE_FULL;
      o_stage_count <= 4'h1;
      o_decim_ratio <= 9'h100;
      o_irq_polarity <= 1'b0;
      o_excitation_enable <= 1'b1;
      o_bias_pct <= 6'h00;
      o_calib_enable <= `SC_STAGES'(0);
      o_skip_samples <= 5'h03;
    end
    else
    begin
      o_mode <= power_mode_e'(next_power_control[`PC_MODE_LSB +: 2]);
      // codes above the maximum clamp to twelve stages
      o_stage_count <= (stg > `STAGE_MAX) ? 4'hC : stg + 4'h1;
      o_decim_ratio <= (dec == 2'h0) ? 9'h100 :
                       (dec == 2'h1) ? 9'h080 : 9'h040;
      o_irq_polarity <= next_power_control[`PC_IRQ_POL_BIT];
      o_excitation_enable <= ~next_power_control[`PC_EXC_DIS_BIT];
      o_bias_pct <= (bia == 2'h0) ? 6'h00 : (bia == 2'h1) ? 6'h14 :
                    (bia == 2'h2) ? 6'h23 : 6'h32;
      o_calib_enable <= next_stage_cal[`SC_STAGES-1:0];
      o_skip_samples <= skip_of(
        power_mode_e'(next_power_control[`PC_MODE_LSB +: 2]),
        next_stage_cal);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (!I_RST_N);

  sequence s_soft_write;
    i_wr && !i_addr_load && ptr == `ADDR_POWER_CONTROL
      && i_wr_data[`PC_SOFT_RESET_BIT];
  endsequence

  a_full_period: assert property (
    o_conv_start && o_mode == MODE_FULL && $stable(power_control)
      |-> tick == 32'h0 && $past(tick) == 32'(FP_INTERVAL_CYC) - 32'h1)
    else $error("full power start not at interval wrap");
  a_shutdown_quiet: assert property (
    state == SEQ_OFF |=> !o_conv_start)
    else $error("conversion start while shut down");
  a_low_wakeup: assert property (
    o_conv_start |-> $past(state) != SEQ_OFF)
    else $error("conversion start without an active mode");
  a_low_delay: assert property (
    next_conv_start && state == SEQ_LOW |-> tick == LP_UNIT_CYC *
      ({30'h0, power_control[`PC_DELAY_LSB +: 2]} + 1) - 1)
    else $error("low power wake delay wrong");
  a_stage_range: assert property (
    o_stage_count >= 4'h1 && o_stage_count <= 4'hC)
    else $error("stage count out of range");
  a_decim_map: assert property (
    ##1 power_control[`PC_DECIM_LSB +: 2] == 2'h3 |-> o_decim_ratio == 9'h040)
    else $error("decimation code 11 not 64");
  a_soft_reset: assert property (
    s_soft_write |=> power_control == `REG_RESET && stage_cal == `REG_RESET)
    else $error("soft reset left a register set");
  a_polarity: assert property (
    ##1 o_irq_polarity == power_control[`PC_IRQ_POL_BIT])
    else $error("irq polarity not following register");
  a_excite: assert property (
    ##1 o_excitation_enable != power_control[`PC_EXC_DIS_BIT])
    else $error("excitation enable not inverted");
  a_reserved_zero: assert property (
    !power_control[`PC_RESERVED_BIT] && !power_control[`PC_SOFT_RESET_BIT])
    else $error("reserved or reset bit held");
  a_read_advance: assert property (
    i_rd && !i_wr && !i_addr_load && ptr != `ADDR_MAX
      |=> o_rd_valid && ptr == $past(ptr) + `ADDR_W'(1))
    else $error("pointer did not advance after read");

endmodule : cdc_power_and_cal_control

/* File: testbench/host_model.sv */
// host processor model: one-cycle strobes on the register access port
// assumes: driven at the falling edge, answer sampled one cycle later
module host_model
(
  // clock
  input wire logic clk,
  // strobes to the register block
  output logic addr_load,
  output logic [9:0] addr,
  output logic wr,
  output logic [15:0] wr_data,
  output logic rd,
  // read answer
  input wire logic [15:0] rd_data,
  input wire logic rd_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    {addr_load, wr, rd} = 3'b000;
    addr = 10'h000;
    wr_data = 16'h0000;
  end
  //////////////////////////////////////////////////////////////////////
  // kind 0 loads the pointer, 1 writes, 2 reads; idle lines show the
  // inverse so a stale value is never mistaken for a live one
  task automatic xfer(input int kind, input logic [15:0] val,
    output logic [15:0] got, output logic vld);
    @(negedge clk);
    addr = val[9:0];
    wr_data = val;
    addr_load = (kind == 0);
    wr = (kind == 1);
    rd = (kind == 2);
    @(negedge clk);
    got = rd_data;
    vld = rd_valid;
    {addr_load, wr, rd} = 3'b000;
    addr = ~addr;
    wr_data = ~wr_data;
  endtask : xfer
endmodule : host_model

/* File: testbench/tb_top.sv */
// self-checking bench for the power and calibration control block
// assumes: host_model issues the strobes; counts shortened for sim
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import cdc_ctrl_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ld, wr, rd, rv, cs, pol, exc, vld;
  logic [9:0] ad;
  logic [15:0] wd, rdd, got, pc = 16'h0000, sc = 16'h0000;
  power_mode_e mode;
  logic [3:0] stc;
  logic [8:0] dec;
  logic [5:0] bias;
  logic [11:0] cal;
  logic [4:0] skip;
  logic [31:0] rng = 32'hE881A976;
  int ptr = 0;
  int n_errors = 0;
  int comparisons = 0;
  always #2 clk = ~clk;
  cdc_power_and_cal_control #(.FP_INTERVAL_CYC(20), .LP_UNIT_CYC(10)) dut
  (
    .I_CLOCK(clk), .I_RST_N(rst_n), .i_addr_load(ld), .i_addr(ad),
    .i_wr(wr), .i_wr_data(wd), .i_rd(rd), .o_rd_data(rdd),
    .o_rd_valid(rv), .o_mode(mode), .o_conv_start(cs),
    .o_stage_count(stc), .o_decim_ratio(dec), .o_irq_polarity(pol),
    .o_excitation_enable(exc), .o_bias_pct(bias), .o_calib_enable(cal),
    .o_skip_samples(skip)
  );
  host_model host
  (
    .clk(clk), .addr_load(ld), .addr(ad), .wr(wr), .wr_data(wd),
    .rd(rd), .rd_data(rdd), .rd_valid(rv)
  );
  //////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] nxt(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : nxt
  task automatic chk(input string nm, input logic [15:0] e,
    input logic [15:0] g);
    comparisons++;
    if (g !== e)
    begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic load(input logic [9:0] a);
    host.xfer(0, {6'h00, a}, got, vld);
    ptr = a;
  endtask : load
  // model keeps pc and sc as the registers should hold them
  task automatic wrm(input logic [15:0] d);
    host.xfer(1, d, got, vld);
    if (ptr == 0)
      {pc, sc} = d[10] ? 32'h0 : {d & 16'hDBFF, sc};
    if (ptr == 1)
      sc = d;
    ptr = (ptr < 1023) ? ptr + 1 : ptr;
  endtask : wrm
  task automatic rdm();
    host.xfer(2, 16'h0000, got, vld);
    chk("rd_valid", 16'h0001, {15'h0, vld});
    chk("rd_data", ptr == 0 ? pc : ptr == 1 ? sc : 16'h0, got);
    ptr = (ptr < 1023) ? ptr + 1 : ptr;
  endtask : rdm
  task automatic chk_out();
    int b[4] = '{0, 20, 35, 50};
    chk("mode", {14'h0, pc[1:0]}, {14'h0, mode});
    chk("stages", pc[7:4] > 4'hB ? 16'hC : pc[7:4] + 16'h1,
      {12'h0, stc});
    chk("decim", pc[9] ? 16'h40 : pc[8] ? 16'h80 : 16'h100,
      {7'h0, dec});
    chk("irq_pol", {15'h0, pc[11]}, {15'h0, pol});
    chk("excite", {15'h0, ~pc[12]}, {15'h0, exc});
    chk("bias", 16'(b[pc[15:14]]), {10'h0, bias});
    chk("calib", {4'h0, sc[11:0]}, {4'h0, cal});
    chk("skip", pc[1:0] == 2'b10 ? (sc[15] ? 16'h2 : {15'h0, sc[14]})
      : (16'h4 << sc[13:12]) - 16'h1, {11'h0, skip});
  endtask : chk_out
  // spacing of the first two start pulses; ffff means only one came
  task automatic period(input int e);
    int t0 = -1;
    int t1 = -1;
    for (int i = 0; i < 200; i++)
    begin
      @(negedge clk);
      t1 = (cs === 1'b1 && t0 >= 0 && t1 < 0) ? i : t1;
      t0 = (cs === 1'b1 && t0 < 0) ? i : t0;
    end
    chk("conv_gap", 16'(e),
      t0 < 0 ? 16'h0 : t1 < 0 ? 16'hFFFF : 16'(t1 - t0));
  endtask : period
  task automatic test_done();
    if (n_errors == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : test_done
  //////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    chk_out();
    load(10'h000);
    repeat (3) rdm();
    // start-up write keeps calibration clear, enables come later
    load(10'h000);
    wrm(16'h82B2);
    wrm(16'h0000);
    load(10'h001);
    wrm(16'h0FFF);
    chk_out();
    // random contents, soft reset included now and then
    repeat (24)
    begin
      rng = nxt(rng);
      load(10'h000);
      wrm(rng[15:0] & 16'hDFFF);
      wrm(rng[31:16]);
      chk_out();
      load(10'h000);
      repeat (2) rdm();
    end
    // every mode against every delay code
    for (int i = 0; i < 16; i++)
    begin
      load(10'h000);
      wrm({12'h000, i[3:0]});
      period(i[1:0] == 2'b00 ? 20 : i[1:0] == 2'b10 ? 10 * (i / 4 + 1)
        : 0);
    end
    // unmapped place, then soft reset over a full calibration register
    load(10'h3FF);
    wrm(16'hFFFF);
    repeat (2) rdm();
    load(10'h001);
    wrm(16'hFFFF);
    load(10'h000);
    wrm(16'h0400);
    chk_out();
    load(10'h000);
    repeat (2) rdm();
    test_done();
  end
  // watchdog: the run needs well under 10000 cycles
  initial
  begin
    #(4 * 40000);
    n_errors++;
    test_done();
  end
endmodule : tb_top
